// [hdl/spi_mode_control_config.sv]
// serial port mode control with ahb-lite registers and shift engine
//
// Summary of operation
// [RQ1] slave role needs sample phase zero; late sampling is master only
// [RQ2] slave select enable set uses select pin in slave role, else ignored
// [RQ3] clock polarity set: clock idles high, active low; clear is opposite
// [RQ4] role bit set makes a clock driving master, clear makes a slave
// [RQ5] prescale code 11,10,01,00 divides by 1,4,16,64 in master role
// [RQ6] clock edge bit must be zero while framed support is on
// [RQ7] primary and secondary prescale never both undivided
// [RQ8] slave select enable must stay clear while framed support is on
// [RQ9] master samples input at end of bit when phase set, middle otherwise
// [RQ10] transfer width bit set gives 16-bit transfers, clear gives 8-bit
// [RQ11] framed support turns select pin into frame sync, direction as configured
// [RQ12] clock disable in master role releases the clock pin
// [RQ13] edge bit set: data changes active-to-idle; clear: idle-to-active
`timescale 1ns/100ps
module spi_mode_control_config import spi_cfg_pkg::*; (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // serial clock pin
    input wire logic sck_in,
    output logic sck_out,
    output logic sck_oe,
    // serial data pins
    input wire logic sdi,
    output logic sdo,
    output logic sdo_oe,
    // select or frame sync pin
    input wire logic sel_in,
    output logic sel_out,
    output logic sel_oe,
    // configuration to neighbouring sections
    output logic master_role,
    output logic idle_high,
    output logic [1:0] primary_prescale,
    output logic framed_support_enable,
    output logic transfer_width_select
);
    typedef struct packed {
        logic [15:0] ctrl_one;
        logic [15:0] ctrl_two;
        bus_phase_type bus;
        logic pend_wr;
        logic [ADDR_W-1:0] pend_addr;
        logic ready;
        logic [31:0] rdata;
        engine_state_type eng;
        logic [5:0] div;
        logic [5:0] half;
        logic [5:0] nbits;
        logic [15:0] tx_sh;
        logic [15:0] rx_sh;
        logic [15:0] rx_data;
        logic rx_valid;
        logic sck_prev;
        logic sck;
        logic sck_en;
        logic sdo;
        logic sdo_en;
        logic sel;
        logic sel_en;
        logic [6:0] gap;
        logic gap_ok;
    } core_state_type;

    localparam core_state_type CORE_RESET = '{
        ctrl_one: CTRL_ONE_RESET, ctrl_two: CTRL_TWO_RESET, bus: BUS_READY,
        eng: ENG_IDLE, ready: 1'b1, default: '0};

    core_state_type q;
    core_state_type d;
    logic master, cke, input_sample_phase, cp, slave_select_enable, w16, dis, en, framed, fs_dir;
    logic [5:0] wbits, two_w, last_h;
    logic [6:0] divisor;
    logic tick, sck_edge, ev, slave_active, sample_ev, start_ev, done_ev, ctrl_one_wr;
    logic [15:0] fifo_data, load_word;
    logic fifo_valid, fifo_ready, pop, push;
    logic [FIFO_CNT_W-1:0] fifo_count;
    logic [31:0] rd_val;

    ////////////////////////////////////////////////////////////////////////////////
    // configuration decode
    assign master = q.ctrl_one[MASTER_ROLE_BIT];
    assign cke = q.ctrl_one[CLOCK_EDGE_BIT];
    assign input_sample_phase = q.ctrl_one[INPUT_SAMPLE_PHASE_BIT];
    assign cp = q.ctrl_one[CLOCK_IDLE_POLARITY_BIT];
    assign slave_select_enable = q.ctrl_one[SLAVE_SELECT_ENABLE_BIT];
    assign w16 = q.ctrl_one[TRANSFER_WIDTH_BIT];
    assign dis = q.ctrl_one[SERIAL_CLOCK_DISABLE_BIT];
    assign en = q.ctrl_two[PORT_ENABLE_BIT];
    assign framed = q.ctrl_two[FRAMED_SUPPORT_BIT];
    assign fs_dir = q.ctrl_two[FRAME_SYNC_DIR_BIT];
    // [RQ10] bits per transfer
    assign wbits = w16 ? BITS_WORD : BITS_BYTE;
    assign two_w = {wbits[4:0], 1'b0};
    // edge-select clear in master role needs one trailing half to close the last bit
    assign last_h = (master && !cke) ? two_w : 6'(two_w - 1'b1);
    // [RQ5] primary prescale divisor
    always_comb begin
        case (q.ctrl_one[PRESCALE_MSB:PRESCALE_LSB])
            PRE_1: divisor = DIV_1;
            PRE_4: divisor = DIV_4;
            PRE_16: divisor = DIV_16;
            default: divisor = DIV_64;
        endcase
    end

    // [RQ4] master ticks from the prescaler, slave follows the pin
    assign tick = (q.eng == ENG_RUN) && master && (q.div == '0);
    assign sck_edge = (q.eng == ENG_RUN) && !master && (sck_in != q.sck_prev);
    assign ev = tick || sck_edge;
    // [RQ2] select pin gates the slave only when enabled
    assign slave_active = en && !master && (!slave_select_enable || !sel_in);
    // [RQ9] sample point: middle of bit, or its end when phase set
    assign sample_ev = ev && (q.half[0] == (!cke ^ input_sample_phase)) && (q.nbits < wbits)
        && !((q.half == '0) && !cke && input_sample_phase);
    assign done_ev = ev && (q.half == last_h);
    assign start_ev = (q.eng == ENG_IDLE) && master && en && fifo_valid
        && (!framed || !fs_dir || sel_in);
    assign load_word = w16 ? fifo_data : {fifo_data[7:0], 8'h00};

    ////////////////////////////////////////////////////////////////////////////////
    // register read mux
    always_comb begin
        if (q.pend_addr == OFS_CTRL_ONE) begin
            rd_val = 32'(q.ctrl_one);
        end else if (q.pend_addr == OFS_CTRL_TWO) begin
            rd_val = 32'(q.ctrl_two);
        end else if (q.pend_addr == OFS_DATA) begin
            rd_val = 32'(q.rx_data);
        end else if (q.pend_addr == OFS_STATUS) begin
            rd_val = '0;
            rd_val[STAT_BUSY_BIT] = (q.eng == ENG_RUN);
            rd_val[STAT_RX_VALID_BIT] = q.rx_valid;
            rd_val[STAT_EMPTY_BIT] = !fifo_valid;
            rd_val[STAT_FULL_BIT] = !fifo_ready;
            rd_val[STAT_COUNT_LSB +: FIFO_CNT_W] = fifo_count;
        end else begin
            rd_val = '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        d = q;
        pop = 1'b0;
        push = 1'b0;
        ctrl_one_wr = 1'b0;
        // bus: at least one wait state per access so read data comes from a flop
        case (q.bus)
            BUS_READY: begin
                if (hsel && hready && htrans[HTRANS_ACTIVE_BIT]) begin
                    d.bus = BUS_DATA;
                    d.pend_wr = hwrite;
                    d.pend_addr = haddr[ADDR_W-1:0];
                    d.ready = 1'b0;
                end
            end
            BUS_DATA: begin
                if (q.pend_wr && (q.pend_addr == OFS_DATA)) begin
                    // full fifo holds the data phase until a word drains
                    push = 1'b1;
                    if (fifo_ready) begin
                        d.bus = BUS_READY;
                        d.ready = 1'b1;
                    end
                end else begin
                    if (q.pend_wr && (q.pend_addr == OFS_CTRL_ONE)) begin
                        d.ctrl_one = hwdata[15:0] & CTRL_ONE_MASK;
                        ctrl_one_wr = 1'b1;
                    end else if (q.pend_wr && (q.pend_addr == OFS_CTRL_TWO)) begin
                        d.ctrl_two = hwdata[15:0] & CTRL_TWO_MASK;
                    end else if (!q.pend_wr) begin
                        d.rdata = rd_val;
                        if (q.pend_addr == OFS_DATA) begin
                            d.rx_valid = 1'b0;
                        end
                    end
                    d.bus = BUS_READY;
                    d.ready = 1'b1;
                end
            end
            default: begin
                d.bus = BUS_READY;
                d.ready = 1'b1;
            end
        endcase

        // shift engine
        d.sck_prev = sck_in;
        d.gap = (q.gap == '1) ? q.gap : 7'(q.gap + 1'b1);
        case (q.eng)
            ENG_IDLE: begin
                // [RQ3] idle clock level
                d.sck = cp;
                if (start_ev || slave_active) begin
                    pop = fifo_valid;
                    d.eng = ENG_RUN;
                    d.half = '0;
                    d.nbits = '0;
                    d.div = 6'(divisor - 1'b1);
                    d.gap = 7'h01;
                    d.gap_ok = 1'b0;
                    d.tx_sh = fifo_valid ? load_word : '0;
                    // [RQ13] edge set presents the first bit before any edge
                    if (cke) begin
                        d.sdo = d.tx_sh[15];
                        d.tx_sh = {d.tx_sh[14:0], 1'b0};
                    end
                end
            end
            ENG_RUN: begin
                if (!en || (!master && !slave_active)) begin
                    // [RQ2] deselect aborts the slave transfer
                    d.eng = ENG_IDLE;
                    d.sck = cp;
                end else if (master && (q.div != '0)) begin
                    d.div = 6'(q.div - 1'b1);
                end else if (ev) begin
                    if (master) begin
                        // [RQ5] reload the prescaler every half period
                        d.div = 6'(divisor - 1'b1);
                        d.gap = 7'h01;
                        d.gap_ok = 1'b1;
                        if (q.half < two_w) begin
                            d.sck = !q.sck;
                        end
                    end
                    // [RQ9] capture input at the chosen point
                    if (sample_ev) begin
                        d.rx_sh = {q.rx_sh[14:0], sdi};
                        d.nbits = 6'(q.nbits + 1'b1);
                    end
                    // [RQ13] output changes on the selected edge
                    if ((q.half[0] == cke) && (q.half < 6'(two_w - 1'b1))) begin
                        d.sdo = q.tx_sh[15];
                        d.tx_sh = {q.tx_sh[14:0], 1'b0};
                    end
                    if (q.half == last_h) begin
                        // [RQ10] word or byte result; set beats a same-cycle read clear
                        d.eng = ENG_IDLE;
                        d.rx_data = w16 ? d.rx_sh : {8'h00, d.rx_sh[7:0]};
                        d.rx_valid = 1'b1;
                        d.sck = cp;
                    end else begin
                        d.half = 6'(q.half + 1'b1);
                    end
                end
            end
            default: begin
                d.eng = ENG_IDLE;
            end
        endcase
        if (ctrl_one_wr) begin
            d.gap_ok = 1'b0;
        end

        // [RQ12] clock pin released when disabled or in slave role
        d.sck_en = en && master && !dis;
        d.sdo_en = en && !q.ctrl_one[DATA_OUT_DISABLE_BIT] && (master || !slave_select_enable || !sel_in);
        // [RQ11] frame sync pulse during the first half bit of a transfer
        d.sel_en = en && framed && !fs_dir;
        d.sel = d.sel_en && (d.eng == ENG_RUN) && (d.half == '0);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q <= CORE_RESET;
        end else begin
            q <= d;
        end
    end

    spi_word_fifo #(
        .WIDTH(DATA_W),
        .DEPTH(FIFO_DEPTH)
    ) tx_fifo (
        .hclk(hclk),
        .hresetn(hresetn),
        .in_valid(push),
        .in_data(hwdata[DATA_W-1:0]),
        .in_ready(fifo_ready),
        .out_valid(fifo_valid),
        .out_data(fifo_data),
        .out_ready(pop),
        .count(fifo_count)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // outputs
    assign hreadyout = q.ready;
    assign hresp = HRESP_OKAY;
    assign hrdata = q.rdata;
    assign sck_out = q.sck;
    assign sck_oe = q.sck_en;
    assign sdo = q.sdo;
    assign sdo_oe = q.sdo_en;
    assign sel_out = q.sel;
    assign sel_oe = q.sel_en;
    assign master_role = q.ctrl_one[MASTER_ROLE_BIT];
    assign idle_high = q.ctrl_one[CLOCK_IDLE_POLARITY_BIT];
    assign primary_prescale = q.ctrl_one[PRESCALE_MSB:PRESCALE_LSB];
    assign framed_support_enable = q.ctrl_two[FRAMED_SUPPORT_BIT];
    assign transfer_width_select = q.ctrl_one[TRANSFER_WIDTH_BIT];

    ////////////////////////////////////////////////////////////////////////////////
    // [RQ2] select pin unused
    chk_select_unused: assert property (@(posedge hclk) disable iff (!hresetn) // [RQ2]
        !master && !slave_select_enable && !framed
        |=> !sel_oe && sdo_oe == $past(en && !q.ctrl_one[DATA_OUT_DISABLE_BIT]))
        else $error("select pin used while slave select is off");
    // [RQ3] idle clock level
    chk_idle_level: assert property (@(posedge hclk) disable iff (!hresetn) // [RQ3]
        q.eng == ENG_IDLE |=> sck_out == $past(cp))
        else $error("clock not at idle level");
    // [RQ4] slave never drives clock
    chk_slave_clock: assert property (@(posedge hclk) disable iff (!hresetn) // [RQ4]
        !master ##1 !master |-> !sck_oe)
        else $error("slave drives the serial clock");
    // [RQ5] prescaled half period
    chk_prescale_gap: assert property (@(posedge hclk) disable iff (!hresetn) // [RQ5]
        tick && q.gap_ok |-> q.gap == divisor)
        else $error("half period differs from prescale divisor");
    // [RQ9] sample point level
    chk_sample_point: assert property (@(posedge hclk) disable iff (!hresetn) // [RQ9]
        master && sample_ev && (q.half < two_w) |=> sck_out == ($past(cp) ^ $past(cke) ^ $past(input_sample_phase)))
        else $error("input sampled at wrong clock edge");
    // [RQ10] bit count per transfer
    chk_bit_count: assert property (@(posedge hclk) disable iff (!hresetn) // [RQ10]
        done_ev && en && (master || (slave_active && !input_sample_phase))
        |=> q.nbits == $past(wbits) && q.rx_valid)
        else $error("transfer length does not match width");
    // [RQ11] frame sync output
    chk_frame_pulse: assert property (@(posedge hclk) disable iff (!hresetn) // [RQ11]
        start_ev && framed && !fs_dir |=> sel_oe && sel_out)
        else $error("no frame sync pulse at transfer start");
    // [RQ12] clock disable
    chk_clock_off: assert property (@(posedge hclk) disable iff (!hresetn) // [RQ12]
        master && dis |=> !sck_oe)
        else $error("clock pin driven while disabled");
    // [RQ13] output change edge
    chk_launch_edge: assert property (@(posedge hclk) disable iff (!hresetn) // [RQ13]
        master && q.eng == ENG_RUN && $stable(q.ctrl_one) && $changed(q.sdo)
        |-> sck_out == (cp ^ !cke))
        else $error("data changed on wrong clock edge");

endmodule : spi_mode_control_config

// [hdl/spi_cfg_pkg.sv]
// shared constants and types for the serial port control block
package spi_cfg_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // sizes
    localparam int DATA_W = 16;
    localparam int FIFO_DEPTH = 16;
    localparam int FIFO_CNT_W = $clog2(FIFO_DEPTH + 1);
    localparam int ADDR_W = 4;

    ////////////////////////////////////////////////////////////////////////////////
    // register byte offsets
    localparam logic [ADDR_W-1:0] OFS_CTRL_ONE = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_CTRL_TWO = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_DATA = 4'h8;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 4'hC;

    // reset values and writable masks
    localparam logic [15:0] CTRL_ONE_RESET = 16'h0000;
    localparam logic [15:0] CTRL_TWO_RESET = 16'h0000;
    localparam logic [15:0] CTRL_ONE_MASK = 16'h1FFF;
    localparam logic [15:0] CTRL_TWO_MASK = 16'hC001;

    // serial_port_control_one fields
    localparam int SERIAL_CLOCK_DISABLE_BIT = 12;
    localparam int DATA_OUT_DISABLE_BIT = 11;
    localparam int TRANSFER_WIDTH_BIT = 10;
    localparam int INPUT_SAMPLE_PHASE_BIT = 9;
    localparam int CLOCK_EDGE_BIT = 8;
    localparam int SLAVE_SELECT_ENABLE_BIT = 7;
    localparam int CLOCK_IDLE_POLARITY_BIT = 6;
    localparam int MASTER_ROLE_BIT = 5;
    localparam int PRESCALE_MSB = 1;
    localparam int PRESCALE_LSB = 0;

    // serial_port_control_two fields
    localparam int FRAMED_SUPPORT_BIT = 15;
    localparam int FRAME_SYNC_DIR_BIT = 14;
    localparam int PORT_ENABLE_BIT = 0;

    // status fields
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_RX_VALID_BIT = 1;
    localparam int STAT_EMPTY_BIT = 2;
    localparam int STAT_FULL_BIT = 3;
    localparam int STAT_COUNT_LSB = 4;

    ////////////////////////////////////////////////////////////////////////////////
    // primary prescale codes and divisors
    localparam logic [1:0] PRE_1 = 2'h3;
    localparam logic [1:0] PRE_4 = 2'h2;
    localparam logic [1:0] PRE_16 = 2'h1;
    localparam logic [1:0] PRE_64 = 2'h0;
    localparam logic [6:0] DIV_1 = 7'h01;
    localparam logic [6:0] DIV_4 = 7'h04;
    localparam logic [6:0] DIV_16 = 7'h10;
    localparam logic [6:0] DIV_64 = 7'h40;

    // bits per transfer
    localparam logic [5:0] BITS_BYTE = 6'h08;
    localparam logic [5:0] BITS_WORD = 6'h10;

    // bus
    localparam int HTRANS_ACTIVE_BIT = 1;
    localparam logic HRESP_OKAY = 1'b0;

    ////////////////////////////////////////////////////////////////////////////////
    // state encodings
    typedef enum logic [1:0] {
        BUS_READY = 2'b01,
        BUS_DATA = 2'b10
    } bus_phase_type;

    typedef enum logic [1:0] {
        ENG_IDLE = 2'b01,
        ENG_RUN = 2'b10
    } engine_state_type;

endpackage : spi_cfg_pkg

// [hdl/spi_word_fifo.sv]
// transmit word fifo with valid/ready on both sides
`timescale 1ns/100ps
module spi_word_fifo import spi_cfg_pkg::*; #(
    parameter int WIDTH = DATA_W,
    parameter int DEPTH = FIFO_DEPTH
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // fill side
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    // drain side
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready,
    // fill level
    output logic [$clog2(DEPTH+1)-1:0] count
);
    localparam int PTR_W = $clog2(DEPTH);
    localparam int CNT_W = $clog2(DEPTH + 1);
    localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);
    localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PTR_W-1:0] wr_ptr;
        logic [PTR_W-1:0] rd_ptr;
        logic [CNT_W-1:0] count;
    } fifo_state_type;

    fifo_state_type q;
    fifo_state_type d;
    logic do_push;
    logic do_pop;

    assign in_ready = (q.count != CNT_FULL);
    assign out_valid = (q.count != '0);
    assign out_data = q.mem[q.rd_ptr];
    assign count = q.count;
    assign do_push = in_valid && in_ready;
    assign do_pop = out_valid && out_ready;

    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        d = q;
        if (do_push) begin
            d.mem[q.wr_ptr] = in_data;
            d.wr_ptr = (q.wr_ptr == PTR_LAST) ? '0 : PTR_W'(q.wr_ptr + 1'b1);
        end
        if (do_pop) begin
            d.rd_ptr = (q.rd_ptr == PTR_LAST) ? '0 : PTR_W'(q.rd_ptr + 1'b1);
        end
        if (do_push && !do_pop) begin
            d.count = CNT_W'(q.count + 1'b1);
        end else if (do_pop && !do_push) begin
            d.count = CNT_W'(q.count - 1'b1);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

endmodule : spi_word_fifo

// [tb/spi_far_slave.sv]
// behavioural serial slave on the far side of the link
`timescale 1ns/100ps
module spi_far_slave (
    // link
    input wire logic sck,
    input wire logic sck_oe,
    input wire logic idle_high,
    input wire logic sdo,
    output logic sdi,
    // bench side
    input wire logic load,
    input wire logic [15:0] reply,
    output logic [15:0] got
);
    logic [15:0] sr = 16'h0000;
    assign sdi = sr[15];
    // sample on leading, shift on trailing
    always @(posedge sck or negedge sck or posedge load) begin
        if (load) begin
            sr <= reply;
            got <= 16'h0000;
        end else if (sck_oe === 1'b1 && sck !== idle_high) begin
            got <= {got[14:0], sdo};
        end else if (sck_oe === 1'b1) begin
            // past the word the line keeps toggling, never a stale level
            sr <= {sr[14:0], ~sr[0]};
        end
    end
endmodule : spi_far_slave

// [tb/testbench.sv]
// self-checking bench for the serial port control block
`timescale 1ns/100ps
module testbench import spi_cfg_pkg::*;;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout, hresp, sck_out, sck_oe, sdi, sdo, sdo_oe, sel_out, sel_oe;
    logic master_role, idle_high, framed_support_enable, transfer_width_select;
    logic [1:0] primary_prescale;
    logic sck_in = 1'b0;
    logic sel_in = 1'b1;
    logic load = 1'b0;
    logic rd_ph = 1'b0;
    logic saw_sync = 1'b0;
    logic [15:0] reply = 16'h0;
    logic [15:0] got;
    logic [31:0] exp_q[$];
    logic [31:0] seed = 32'd22736;
    logic [31:0] v;
    int fails = 0;
    int cmp_count = 0;
    always #20 hclk = ~hclk;
    spi_mode_control_config i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .sck_in(sck_in),
        .sck_out(sck_out), .sck_oe(sck_oe), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe),
        .sel_in(sel_in), .sel_out(sel_out), .sel_oe(sel_oe), .master_role(master_role),
        .idle_high(idle_high), .primary_prescale(primary_prescale),
        .framed_support_enable(framed_support_enable),
        .transfer_width_select(transfer_width_select));
    spi_far_slave i_far (.sck(sck_out), .sck_oe(sck_oe), .idle_high(idle_high), .sdo(sdo),
        .sdi(sdi), .load(load), .reply(reply), .got(got));
    ////////////////////////////////
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd
    task automatic conclude();
        $display("TB: %0d mismatches in %0d comparisons", fails, cmp_count);
        if (fails == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : conclude
    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
        end
    endtask : cmp
    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 300);
        if (hreadyout !== 1'b1) begin
            fails++;
            conclude();
        end
    endtask : wait_ready
    // reads note their expectation, the monitor compares it
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {28'h0, a};
        hwrite <= wr;
        htrans <= 2'h2;
        wait_ready();
        htrans <= 2'h0;
        hwdata <= d;
        if (!wr) begin
            exp_q.push_back(d);
        end
        rd_ph <= !wr;
        wait_ready();
        rd_ph <= 1'b0;
    endtask : bus
    always @(posedge hclk) begin
        if (rd_ph && hreadyout === 1'b1) begin
            cmp(hrdata, exp_q.pop_front());
        end
        if (sel_out === 1'b1) begin
            saw_sync <= 1'b1;
        end
        sck_in <= rnd() & 32'h1;
    end
    task automatic xfer(input logic [1:0] code, input logic pol, input logic wide, input logic frm);
        logic [15:0] tx;
        logic [15:0] rx;
        int div;
        int n;
        tx = 16'(wide ? rnd() : rnd() & 32'hFF);
        rx = 16'(rnd());
        div = 64 >> (2 * code);
        bus(1'b1, OFS_CTRL_TWO, 32'h0);
        bus(1'b1, OFS_CTRL_ONE, {21'h0, wide, wide, !frm, 1'b0, pol, 1'b1, 3'h0, code});
        cmp(primary_prescale, code);
        reply <= wide ? rx : {rx[7:0], 8'h00};
        load <= 1'b1;
        bus(1'b1, OFS_CTRL_TWO, {16'h0, frm, 14'h0, 1'b1});
        load <= 1'b0;
        // pin enables settle one edge after the register write
        @(posedge hclk);
        cmp(sck_out, pol);
        cmp(sck_oe, 1'b1);
        cmp(sel_oe, frm);
        saw_sync <= 1'b0;
        bus(1'b1, OFS_DATA, 32'(tx));
        n = 0;
        while (sck_out === pol && n < 200) begin
            @(posedge hclk);
            n++;
        end
        if (n >= 200) begin
            fails++;
            conclude();
        end
        n = 0;
        while (sck_out !== pol && n < 200) begin
            @(posedge hclk);
            n++;
        end
        if (n >= 200) begin
            fails++;
            conclude();
        end
        cmp(n, div);
        repeat ((wide ? 32 : 16) * div + 16) @(posedge hclk);
        if (frm) begin
            cmp(saw_sync, 1'b1);
        end else begin
            cmp(got, tx);
            bus(1'b0, OFS_DATA, wide ? rx : rx & 32'hFF);
        end
    endtask : xfer
    ////////////////////////////////
    initial begin
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        cmp(hreadyout, 1'b1);
        cmp(hresp, HRESP_OKAY);
        bus(1'b0, OFS_CTRL_ONE, 32'h0);
        repeat (4) begin
            v = rnd() & 32'hFFFF;
            // slave role keeps sample phase clear
            v[9] = v[9] & v[5];
            bus(1'b1, OFS_CTRL_ONE, v);
            bus(1'b0, OFS_CTRL_ONE, v & 32'h1FFF);
            cmp(master_role, v[5]);
            cmp(idle_high, v[6]);
            cmp(transfer_width_select, v[10]);
        end
        for (int c = 0; c < 4; c++) begin
            xfer(2'(c), c[0], c[1], 1'b0);
        end
        xfer(PRE_4, 1'b0, 1'b0, 1'b1);
        cmp(framed_support_enable, 1'b1);
        bus(1'b1, OFS_CTRL_ONE, 32'h1020);
        @(posedge hclk);
        cmp(sck_oe, 1'b0);
        // fill with the port off, then drain at full rate
        bus(1'b1, OFS_CTRL_TWO, 32'h0);
        repeat (16) bus(1'b1, OFS_DATA, rnd() & 32'hFFFF);
        bus(1'b0, OFS_STATUS, 32'h10A);
        bus(1'b1, OFS_CTRL_ONE, 32'h0123);
        bus(1'b1, OFS_CTRL_TWO, 32'h1);
        repeat (800) @(posedge hclk);
        bus(1'b0, OFS_STATUS, 32'h6);
        // slave with select enable waits for the select pin
        bus(1'b1, OFS_CTRL_ONE, 32'h0080);
        @(posedge hclk);
        cmp(sdo_oe, 1'b0);
        sel_in <= 1'b0;
        repeat (2) @(posedge hclk);
        cmp(sdo_oe, 1'b1);
        sel_in <= 1'b1;
        conclude();
    end
endmodule : testbench
